/* hdl/ptr_trip_ctrl.sv */
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
// Operation
// - reluctance pin low forces all three low-side timing signals permanently on
// - in reluctance mode high sides still follow the three duty registers
// - crossover still applies in reluctance mode, swapping high and low outputs
// - reluctance mode set only by pin level; high or floating disables it
// - low trip pin shuts the pwm down; outputs go to polarity off level
// - during shutdown in reluctance mode the low-side signals stay on
// - any shutdown suppresses sync pulse and its interrupt; timer keeps counting
// - trip pin level readable as bit 0 of system status
// - enabled general io line falling edge triggers the same shutdown
// - trip enable resets to 0x0FFF; the shutdown latch resets set, so pwm starts shut down
// - any write to software trip register issues a shutdown
// - hardware trips leave the software trip register unchanged
// - software trip reads one after software shutdown; every read clears it
// - software trips always raise the trip interrupt; pin and io line trips raise it only when not already shut down
// - restart only after rewrites and trip pin and enabled lines are high
// - polarity pin low gives active low outputs, high gives active high
module ptr_trip_ctrl #(
    parameter int NUM_IO = 12,
    parameter int CNT_W = 16
)(
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reluctance_mode_pin_n,
    input wire logic fault_trip_pin_n,
    input wire logic output_polarity_pin,
    input wire logic [NUM_IO-1:0] general_io_line,
    output ptr_pkg::ptr_pwm_s pwm_out,
    output logic cycle_sync_pulse,
    output logic irq
);

    // the enable register has twelve bits, so more lines could never trip
    if (NUM_IO < 1 || NUM_IO > 12)
        $error("NUM_IO must be 1 to 12");
    if (CNT_W < 2 || CNT_W > 32)
        $error("CNT_W must be 2 to 32");

    // pin synchronisers; stage one feeds stage two only
    logic rel_s1_q, rel_s2_q;
    logic trip_s1_q, trip_s2_q;
    logic pol_s1_q, pol_s2_q;
    logic [NUM_IO-1:0] io_s1_q, io_s2_q, io_prev_q;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rel_s1_q <= 1'b1;
            rel_s2_q <= 1'b1;
            trip_s1_q <= 1'b0;
            trip_s2_q <= 1'b0;
            pol_s1_q <= 1'b1;
            pol_s2_q <= 1'b1;
            io_s1_q <= '0;
            io_s2_q <= '0;
            io_prev_q <= '0;
        end
        else
        begin
            rel_s1_q <= reluctance_mode_pin_n;
            rel_s2_q <= rel_s1_q;
            trip_s1_q <= fault_trip_pin_n;
            trip_s2_q <= trip_s1_q;
            pol_s1_q <= output_polarity_pin;
            pol_s2_q <= pol_s1_q;
            io_s1_q <= general_io_line;
            io_s2_q <= io_s1_q;
            io_prev_q <= io_s2_q;
        end
    end

    logic reluctance_mode;
    assign reluctance_mode = ~rel_s2_q;

    // bus decode: one wait state, answer in second access cycle
    logic acc_first, acc_done, wr_en, rd_en;
    assign acc_first = psel & penable & ~pready;
    assign acc_done = psel & penable & pready;
    assign wr_en = acc_done & pwrite;
    assign rd_en = acc_done & ~pwrite;

    logic [11:0] trip_en_q;
    logic [NUM_IO-1:0] io_en;
    logic sw_trip_q;
    logic [ptr_pkg::IRQ_W-1:0] irq_status_q, irq_mask_q;
    logic [CNT_W-1:0] period_q, duty_a_q, duty_b_q, duty_c_q;
    logic [2:0] xo_q;
    logic shut_q;
    logic [3:0] rewrite_q;
    logic [CNT_W-1:0] cnt_q, act_a_q, act_b_q, act_c_q;
    logic wrap;

    assign io_en = NUM_IO'(trip_en_q);

    logic wr_sw_trip, wr_period, wr_a, wr_b, wr_c;
    assign wr_sw_trip = wr_en && paddr == ptr_pkg::OFF_SW_TRIP;
    assign wr_period = wr_en && paddr == ptr_pkg::OFF_PERIOD;
    assign wr_a = wr_en && paddr == ptr_pkg::OFF_DUTY_A;
    assign wr_b = wr_en && paddr == ptr_pkg::OFF_DUTY_B;
    assign wr_c = wr_en && paddr == ptr_pkg::OFF_DUTY_C;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            trip_en_q <= ptr_pkg::RST_PIO_TRIP_EN;
            irq_mask_q <= ptr_pkg::RST_IRQ_MASK;
            period_q <= CNT_W'(ptr_pkg::RST_PERIOD);
            duty_a_q <= CNT_W'(ptr_pkg::RST_DUTY);
            duty_b_q <= CNT_W'(ptr_pkg::RST_DUTY);
            duty_c_q <= CNT_W'(ptr_pkg::RST_DUTY);
            xo_q <= ptr_pkg::RST_CROSSOVER;
        end
        else if (wr_en)
        begin
            case (paddr)
                ptr_pkg::OFF_PIO_TRIP_EN: trip_en_q <= pwdata[11:0];
                ptr_pkg::OFF_IRQ_MASK: irq_mask_q <= pwdata[ptr_pkg::IRQ_W-1:0];
                ptr_pkg::OFF_PERIOD: period_q <= pwdata[CNT_W-1:0];
                ptr_pkg::OFF_DUTY_A: duty_a_q <= pwdata[CNT_W-1:0];
                ptr_pkg::OFF_DUTY_B: duty_b_q <= pwdata[CNT_W-1:0];
                ptr_pkg::OFF_DUTY_C: duty_c_q <= pwdata[CNT_W-1:0];
                ptr_pkg::OFF_CROSSOVER: xo_q <= pwdata[2:0];
                default:
                begin
                end
            endcase
        end
    end

    // software trip flag: only bus traffic touches it, never a pin trip
    always_ff @(posedge clk)
    begin
        if (reset)
            sw_trip_q <= 1'b0;
        else if (wr_sw_trip)
            sw_trip_q <= 1'b1;
        else if (rd_en && paddr == ptr_pkg::OFF_SW_TRIP)
            sw_trip_q <= 1'b0;
    end

    // shutdown command from any source
    logic trip_cmd, sources_clear, restart;
    assign trip_cmd = ~trip_s2_q
        | (|(io_en & io_prev_q & ~io_s2_q))
        | wr_sw_trip;
    assign sources_clear = trip_s2_q & ~(|(io_en & ~io_s2_q));
    assign restart = shut_q && rewrite_q == ptr_pkg::RW_ALL && sources_clear;

    // latch holds after the source goes away; starts set out of reset
    always_ff @(posedge clk)
    begin
        if (reset)
            shut_q <= 1'b1;
        else if (trip_cmd)
            shut_q <= 1'b1;
        else if (restart)
            shut_q <= 1'b0;
    end

    // rewrite tracking; a write landing with a new trip is lost
    always_ff @(posedge clk)
    begin
        if (reset)
            rewrite_q <= '0;
        else if (restart || (trip_cmd && !shut_q))
            rewrite_q <= '0;
        else if (shut_q)
        begin
            if (wr_period)
                rewrite_q[ptr_pkg::RW_PERIOD_BIT] <= 1'b1;
            if (wr_a)
                rewrite_q[ptr_pkg::RW_DUTY_A_BIT] <= 1'b1;
            if (wr_b)
                rewrite_q[ptr_pkg::RW_DUTY_B_BIT] <= 1'b1;
            if (wr_c)
                rewrite_q[ptr_pkg::RW_DUTY_C_BIT] <= 1'b1;
        end
    end

    // timer keeps running through shutdown
    assign wrap = cnt_q >= period_q - CNT_W'(1);

    always_ff @(posedge clk)
    begin
        if (reset)
            cnt_q <= '0;
        else if (wrap)
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + CNT_W'(1);
    end

    // duties take effect at cycle start
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            act_a_q <= '0;
            act_b_q <= '0;
            act_c_q <= '0;
        end
        else if (wrap)
        begin
            act_a_q <= duty_a_q;
            act_b_q <= duty_b_q;
            act_c_q <= duty_c_q;
        end
    end

    // interrupt status, write one to clear; a new event beats the clear
    logic [ptr_pkg::IRQ_W-1:0] irq_set, irq_clr;
    always_comb
    begin
        irq_set = '0;
        irq_set[ptr_pkg::IRQ_TRIP_BIT] = trip_cmd & ~shut_q;
        irq_set[ptr_pkg::IRQ_TRIP_BIT] = irq_set[ptr_pkg::IRQ_TRIP_BIT] | wr_sw_trip;
        irq_set[ptr_pkg::IRQ_SYNC_BIT] = wrap & ~shut_q;
        irq_clr = '0;
        if (wr_en && paddr == ptr_pkg::OFF_IRQ_STATUS)
            irq_clr = pwdata[ptr_pkg::IRQ_W-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            irq_status_q <= '0;
        else
            irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            irq <= 1'b0;
        else
            irq <= |(irq_status_q & irq_mask_q);
    end

    // timing unit signals per phase
    function automatic ptr_pkg::ptr_pair_s phase_sig(
        input logic [CNT_W-1:0] cnt,
        input logic [CNT_W-1:0] duty,
        input logic rel,
        input logic shut,
        input logic xo
    );
        ptr_pkg::ptr_pair_s p;
        p.hi = ~shut & (cnt < duty);
        p.lo = rel ? 1'b1 : (~shut & ~(cnt < duty));
        if (xo)
            p = '{hi: p.lo, lo: p.hi};
        return p;
    endfunction

    ptr_pkg::ptr_pair_s pa, pb, pc;
    assign pa = phase_sig(cnt_q, act_a_q, reluctance_mode, shut_q, xo_q[ptr_pkg::XO_A_BIT]);
    assign pb = phase_sig(cnt_q, act_b_q, reluctance_mode, shut_q, xo_q[ptr_pkg::XO_B_BIT]);
    assign pc = phase_sig(cnt_q, act_c_q, reluctance_mode, shut_q, xo_q[ptr_pkg::XO_C_BIT]);

    // polarity low means on is driven low
    ptr_pkg::ptr_pwm_s pwm_act;
    assign pwm_act = '{ah: pa.hi, al: pa.lo, bh: pb.hi, bl: pb.lo, ch: pc.hi, cl: pc.lo};

    always_ff @(posedge clk)
    begin
        if (reset)
            pwm_out <= '0;
        else
            pwm_out <= pol_s2_q ? pwm_act : ~pwm_act;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            cycle_sync_pulse <= 1'b0;
        else
            cycle_sync_pulse <= wrap & ~shut_q;
    end

    // read mux
    logic [31:0] rd_d;
    logic hit;
    always_comb
    begin
        rd_d = '0;
        hit = 1'b1;
        case (paddr)
            ptr_pkg::OFF_PIO_TRIP_EN: rd_d[11:0] = trip_en_q;
            ptr_pkg::OFF_SW_TRIP: rd_d[0] = sw_trip_q;
            ptr_pkg::OFF_SYS_STATUS:
            begin
                rd_d[ptr_pkg::SYS_TRIP_PIN_BIT] = trip_s2_q;
                rd_d[ptr_pkg::SYS_SHUTDOWN_BIT] = shut_q;
                rd_d[ptr_pkg::SYS_POLARITY_BIT] = pol_s2_q;
                rd_d[ptr_pkg::SYS_RELUCTANCE_BIT] = reluctance_mode;
            end
            ptr_pkg::OFF_IRQ_STATUS: rd_d[ptr_pkg::IRQ_W-1:0] = irq_status_q;
            ptr_pkg::OFF_IRQ_MASK: rd_d[ptr_pkg::IRQ_W-1:0] = irq_mask_q;
            ptr_pkg::OFF_PERIOD: rd_d[CNT_W-1:0] = period_q;
            ptr_pkg::OFF_DUTY_A: rd_d[CNT_W-1:0] = duty_a_q;
            ptr_pkg::OFF_DUTY_B: rd_d[CNT_W-1:0] = duty_b_q;
            ptr_pkg::OFF_DUTY_C: rd_d[CNT_W-1:0] = duty_c_q;
            ptr_pkg::OFF_CROSSOVER: rd_d[2:0] = xo_q;
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= acc_first;
            prdata <= (acc_first && !pwrite) ? rd_d : 32'h0000_0000;
            pslverr <= acc_first & ~hit;
        end
    end

endmodule

/* common/ptr_pkg.sv */
package ptr_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_PIO_TRIP_EN = 8'h00;
    localparam logic [7:0] OFF_SW_TRIP = 8'h04;
    localparam logic [7:0] OFF_SYS_STATUS = 8'h08;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFF_PERIOD = 8'h14;
    localparam logic [7:0] OFF_DUTY_A = 8'h18;
    localparam logic [7:0] OFF_DUTY_B = 8'h1C;
    localparam logic [7:0] OFF_DUTY_C = 8'h20;
    localparam logic [7:0] OFF_CROSSOVER = 8'h24;

    // reset values
    localparam logic [11:0] RST_PIO_TRIP_EN = 12'hFFF;
    localparam logic [15:0] RST_PERIOD = 16'h0000;
    localparam logic [15:0] RST_DUTY = 16'h0000;
    localparam logic [2:0] RST_CROSSOVER = 3'h0;
    localparam logic [1:0] RST_IRQ_MASK = 2'h0;

    // system status fields
    localparam int SYS_TRIP_PIN_BIT = 0;
    localparam int SYS_SHUTDOWN_BIT = 1;
    localparam int SYS_POLARITY_BIT = 2;
    localparam int SYS_RELUCTANCE_BIT = 3;

    // interrupt status / mask fields
    localparam int IRQ_TRIP_BIT = 0;
    localparam int IRQ_SYNC_BIT = 1;
    localparam int IRQ_W = 2;

    // crossover fields, one per phase
    localparam int XO_C_BIT = 0;
    localparam int XO_B_BIT = 1;
    localparam int XO_A_BIT = 2;

    // restart needs all four of these rewritten
    localparam int RW_PERIOD_BIT = 0;
    localparam int RW_DUTY_A_BIT = 1;
    localparam int RW_DUTY_B_BIT = 2;
    localparam int RW_DUTY_C_BIT = 3;
    localparam logic [3:0] RW_ALL = 4'hF;

    typedef struct packed {
        logic ah;
        logic al;
        logic bh;
        logic bl;
        logic ch;
        logic cl;
    } ptr_pwm_s;

    typedef struct packed {
        logic hi;
        logic lo;
    } ptr_pair_s;

endpackage

/* dv/ptr_trip_chk.sv */
`timescale 1ns/1ps
module ptr_trip_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic reluctance_mode_pin_n,
    input wire logic fault_trip_pin_n,
    input wire logic output_polarity_pin,
    input wire ptr_pkg::ptr_pwm_s pwm_out,
    input wire logic cycle_sync_pulse
);
    logic swt_hit;
    logic swt_q;
    logic swt_ok_q;
    logic pol;
    ptr_pkg::ptr_pwm_s o;
    assign swt_hit = psel && penable && pready && paddr == ptr_pkg::OFF_SW_TRIP;
    assign pol = output_polarity_pin;
    assign o = pwm_out;
    // flag value is only predictable once software has touched it
    always_ff @(posedge clk)
    begin
        if (reset)
            swt_ok_q <= 1'b0;
        else if (swt_hit)
            swt_ok_q <= 1'b1;
    end
    always_ff @(posedge clk)
    begin
        if (swt_hit)
            swt_q <= pwrite;
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("no ready");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held");
    err_reply_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error reply");
    trip_off_a: assert property (
        (!fault_trip_pin_n && reluctance_mode_pin_n && $stable(pol))[*6]
        |-> o == {6{!pol}})
        else $error("outputs not off");
    rel_on_a: assert property (
        (!reluctance_mode_pin_n && $stable(pol))[*6]
        |-> (o.ah == pol || o.al == pol) && (o.bh == pol || o.bl == pol)
        && (o.ch == pol || o.cl == pol))
        else $error("low side not on");
    rel_split_a: assert property (
        (!fault_trip_pin_n && !reluctance_mode_pin_n && $stable(pol))[*6]
        |-> o.ah != o.al && o.bh != o.bl && o.ch != o.cl)
        else $error("bad reluctance trip");
    sync_stop_a: assert property ((!fault_trip_pin_n)[*6] |-> !cycle_sync_pulse)
        else $error("sync in trip");
    swt_read_a: assert property (
        swt_hit && !pwrite && swt_ok_q |-> prdata[0] == swt_q)
        else $error("bad trip flag");
endmodule

bind ptr_trip_ctrl ptr_trip_chk chk_u (.clk, .reset, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .reluctance_mode_pin_n, .fault_trip_pin_n,
    .output_polarity_pin, .pwm_out, .cycle_sync_pulse);

/* dv/ptr_drv_model.sv */
`timescale 1ns/1ps
module ptr_drv_model (
    input wire logic flt,
    input wire logic [11:0] io_low,
    input wire logic pol,
    input wire ptr_pkg::ptr_pwm_s pwm,
    output logic trip_n,
    output logic [11:0] io,
    output logic [5:0] sw_on
);
    // fault circuit sinks the lines; released lines return high
    assign trip_n = !flt;
    assign io = ~io_low;
    assign sw_on = pol ? pwm : ~pwm;
endmodule

/* dv/tb_pwm_trip_and_reluctance_mode.sv */
`timescale 1ns/1ps
module tb_pwm_trip_and_reluctance_mode;
    logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, trip_n, sync, irq;
    logic rel_n = 1'b1, pol = 1'b1, flt = 1'b0;
    logic [11:0] io_low = 12'h000, io;
    logic [5:0] sw_on;
    ptr_pkg::ptr_pwm_s pwm;
    logic [64:0] notes[$];
    logic [64:0] nt;
    int errors = 0, n_checks = 0, nsync, k;
    int cnt[5:0];
    int d[3];
    always #5 clk = ~clk;
    ptr_trip_ctrl dut_u (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .reluctance_mode_pin_n(rel_n), .fault_trip_pin_n(trip_n),
        .output_polarity_pin(pol), .general_io_line(io), .pwm_out(pwm),
        .cycle_sync_pulse(sync), .irq);
    ptr_drv_model drv_u (.flt, .io_low, .pol, .pwm, .trip_n, .io, .sw_on);
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // reads note value and mask; writes note zero with an empty mask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
        input logic [31:0] m);
        @(posedge clk);
        notes.push_back({a > ptr_pkg::OFF_CROSSOVER, m, v & m});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(negedge clk);
        while (pready !== 1'b1);
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    always @(posedge clk)
    begin
        if (psel && penable && pready)
        begin
            nt = notes.pop_front();
            chk({31'h0, pslverr}, {31'h0, nt[64]});
            chk(prdata & nt[63:32], nt[31:0]);
        end
    end
    // one switching period: on-cycles per switch and sync pulses
    task automatic expect_on(input int e[5:0], input int s);
        nsync = 0;
        cnt = '{default: 0};
        repeat (8)
        begin
            @(negedge clk);
            nsync += int'(sync);
            for (int i = 0; i < 6; i++)
                cnt[i] += int'(sw_on[i]);
        end
        for (int i = 0; i < 6; i++)
            chk(32'(cnt[i]), 32'(e[i]));
        chk(32'(nsync), 32'(s));
    endtask
    task automatic restart(input int n);
        apb(1'b1, ptr_pkg::OFF_PERIOD, 32'h8, 32'h0);
        for (int p = 0; p < n; p++)
            apb(1'b1, ptr_pkg::OFF_DUTY_A + 8'(4 * p), 32'(d[p]), 32'h0);
    endtask
    initial
    begin
        void'($urandom(1));
        d = '{0, $urandom_range(7, 1), 8};
        k = $urandom_range(11, 0);
        repeat (10)
            @(posedge clk);
        reset <= 1'b0;
        apb(1'b0, ptr_pkg::OFF_PIO_TRIP_EN, 32'hFFF, 32'hFFF);
        apb(1'b0, ptr_pkg::OFF_SYS_STATUS, 32'h3, 32'h3);
        apb(1'b0, ptr_pkg::OFF_CROSSOVER, 32'h0, 32'h7);
        apb(1'b0, 8'h28, 32'h0, 32'hFFFFFFFF);
        apb(1'b1, ptr_pkg::OFF_PIO_TRIP_EN, 32'h1 << k, 32'h0);
        apb(1'b1, ptr_pkg::OFF_IRQ_MASK, 32'h1, 32'h0);
        apb(1'b1, ptr_pkg::OFF_IRQ_STATUS, 32'h3, 32'h0);
        restart(3);
        // a line that is not enabled must not trip
        io_low <= 12'h1 << ((k + 1) % 12);
        repeat (6)
            @(posedge clk);
        apb(1'b0, ptr_pkg::OFF_SYS_STATUS, 32'h1, 32'h3);
        io_low <= 12'h0;
        for (int q = 0; q < 2; q++)
        begin
            @(posedge clk);
            pol <= q[0];
            repeat (12)
                @(posedge clk);
            expect_on('{d[0], 8 - d[0], d[1], 8 - d[1], d[2], 8 - d[2]}, 1);
        end
        for (int s = 0; s < 3; s++)
        begin
            @(posedge clk);
            if (s == 0)
                flt <= 1'b1;
            else if (s == 1)
                io_low <= 12'h1 << k;
            else
                apb(1'b1, ptr_pkg::OFF_SW_TRIP, $urandom, 32'h0);
            repeat (6)
                @(posedge clk);
            expect_on('{default: 0}, 0);
            chk({31'h0, irq}, 32'h1);
            apb(1'b0, ptr_pkg::OFF_SW_TRIP, 32'(s == 2), 32'h1);
            apb(1'b0, ptr_pkg::OFF_SW_TRIP, 32'h0, 32'h1);
            restart(s == 0 ? 3 : 2);
            apb(1'b0, ptr_pkg::OFF_SYS_STATUS, 32'(s != 0) | 32'h2, 32'h3);
            flt <= 1'b0;
            io_low <= 12'h0;
            if (s != 0)
                apb(1'b1, ptr_pkg::OFF_DUTY_C, 32'(d[2]), 32'h0);
            repeat (6)
                @(posedge clk);
            apb(1'b0, ptr_pkg::OFF_SYS_STATUS, 32'h1, 32'h3);
            apb(1'b1, ptr_pkg::OFF_IRQ_STATUS, 32'h1, 32'h0);
            repeat (3)
                @(posedge clk);
            chk({31'h0, irq}, 32'h0);
        end
        rel_n <= 1'b0;
        repeat (12)
            @(posedge clk);
        expect_on('{d[0], 8, d[1], 8, d[2], 8}, 1);
        apb(1'b1, ptr_pkg::OFF_CROSSOVER, 32'h4, 32'h0);
        repeat (12)
            @(posedge clk);
        expect_on('{8, d[0], d[1], 8, d[2], 8}, 1);
        @(posedge clk);
        flt <= 1'b1;
        repeat (8)
            @(posedge clk);
        expect_on('{8, 0, 0, 8, 0, 8}, 0);
        report_and_stop();
    end
    initial
    begin
        repeat (20000)
            @(posedge clk);
        errors++;
        report_and_stop();
    end
endmodule
